//--- conditional_branch_unit.sv
// Behaviour
// (RL1) opcode E6 branches when negative is set
// (RL2) opcode E3 branches when carry is clear
// (RL3) opcode E7 branches when negative is clear
// (RL4) opcode E5 branches when overflow is clear
// (RL5) opcode E1 branches when zero is clear
// (RL6) low byte is signed offset, -128..127
// (RL7) offset doubled as two's complement displacement
// (RL8) taken target is own address plus two plus displacement
// (RL9) one word; one cycle, two when taken
// (RL10) not taken: pc moves to next word
// (RL11) flags untouched; taken second cycle idles
// (RL12) not taken: last phase writes nothing
module conditional_branch_unit #(
    parameter int PC_WIDTH  = 16,
    parameter int CNT_WIDTH = 16
) (
    input  wire logic                         mclk,
    input  wire logic                         rstn,
    input  wire logic [branch_pkg::BUS_AW-1:0] avs_address,
    input  wire logic                         avs_read,
    input  wire logic                         avs_write,
    input  wire logic [branch_pkg::BUS_DW-1:0] avs_writedata,
    input  wire logic [3:0]                   avs_byteenable,
    output logic      [branch_pkg::BUS_DW-1:0] avs_readdata,
    output logic                              avs_waitrequest,
    input  wire logic                         carry,
    input  wire logic                         zero,
    input  wire logic                         overflow,
    input  wire logic                         negative,
    output logic      [PC_WIDTH-1:0]          pc_value,
    output logic                              pc_write,
    output logic                              busy,
    output logic                              taken
);

    if (PC_WIDTH < branch_pkg::PC_MIN_WIDTH || PC_WIDTH > branch_pkg::PC_MAX_WIDTH) begin : g_bad_pc
        $error("PC_WIDTH out of range");
    end
    if (CNT_WIDTH < 1 || CNT_WIDTH > branch_pkg::BUS_DW) begin : g_bad_cnt
        $error("CNT_WIDTH out of range");
    end

    localparam int BUS_DW = branch_pkg::BUS_DW;

    branch_pkg::seq_state_e state_reg;
    branch_pkg::seq_state_e state_next;

    logic [branch_pkg::INSTR_WIDTH-1:0] instr_reg;
    logic [PC_WIDTH-1:0]                pc_reg;
    logic [PC_WIDTH-1:0]                base_reg;
    logic [PC_WIDTH-1:0]                disp_reg;
    logic                               taken_reg;
    logic                               foreign_reg;
    logic                               pc_write_reg;
    logic                               busy_reg;
    logic [CNT_WIDTH-1:0]               taken_cnt_reg;
    logic [CNT_WIDTH-1:0]               fall_cnt_reg;
    logic                               wait_reg;
    logic [branch_pkg::BUS_DW-1:0]      rdata_reg;

    logic [2:0]                    reg_idx;
    logic                          bus_req;
    logic                          bus_blocked;
    logic                          wr_ack;
    logic [branch_pkg::BUS_DW-1:0] lane_mask;
    logic [branch_pkg::BUS_DW-1:0] instr_merged;
    logic [branch_pkg::BUS_DW-1:0] pc_merged;
    logic [branch_pkg::BUS_DW-1:0] read_mux;
    logic [branch_pkg::BUS_DW-1:0] status_word;
    logic                          dec_branch;
    logic                          dec_take;
    logic [PC_WIDTH-1:0]           step;

    assign step = PC_WIDTH'(branch_pkg::PC_STEP);

    // bus decode
    assign reg_idx = avs_address[branch_pkg::BUS_AW-1:2];
    assign bus_req = avs_read | avs_write;
    // instruction and pc writes wait while a cycle runs, so software cannot tear the pc
    assign bus_blocked = avs_write && state_reg != branch_pkg::ST_IDLE &&
                         (reg_idx == branch_pkg::REG_INSTR || reg_idx == branch_pkg::REG_PC);
    assign wr_ack = avs_write && !wait_reg;

    for (genvar i = 0; i < 4; i++) begin : g_lane
        assign lane_mask[8*i +: 8] = {8{avs_byteenable[i]}};
    end

    assign instr_merged = (BUS_DW'(instr_reg) & ~lane_mask) | (avs_writedata & lane_mask);
    assign pc_merged    = (BUS_DW'(pc_reg) & ~lane_mask) | (avs_writedata & lane_mask);

    always_comb begin
        status_word = '0;
        status_word[branch_pkg::ST_BUSY_BIT]    = busy_reg;
        status_word[branch_pkg::ST_TAKEN_BIT]   = taken_reg;
        status_word[branch_pkg::ST_FOREIGN_BIT] = foreign_reg;
        status_word[branch_pkg::ST_SECOND_BIT]  = state_reg inside {branch_pkg::ST_N1, branch_pkg::ST_N2,
                                                                   branch_pkg::ST_N3, branch_pkg::ST_N4};
        status_word[branch_pkg::ST_CARRY_BIT]   = carry;
        status_word[branch_pkg::ST_ZERO_BIT]    = zero;
        status_word[branch_pkg::ST_OVF_BIT]     = overflow;
        status_word[branch_pkg::ST_NEG_BIT]     = negative;
    end

    always_comb begin
        case (reg_idx)
            branch_pkg::REG_INSTR:     read_mux = BUS_DW'(instr_reg);
            branch_pkg::REG_PC:        read_mux = BUS_DW'(pc_reg);
            branch_pkg::REG_STATUS:    read_mux = status_word;
            branch_pkg::REG_TAKEN_CNT: read_mux = BUS_DW'(taken_cnt_reg);
            branch_pkg::REG_FALL_CNT:  read_mux = BUS_DW'(fall_cnt_reg);
            default:                   read_mux = '0;
        endcase
    end

    // waitrequest drops for exactly one cycle per accepted request
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wait_reg <= 1'h1;
        end else if (bus_req && wait_reg && !bus_blocked) begin
            wait_reg <= 1'h0;
        end else begin
            wait_reg <= 1'h1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdata_reg <= '0;
        end else if (avs_read && wait_reg) begin
            rdata_reg <= read_mux;
        end
    end

    cond_branch_decode u_decode (
        .opcode_hi (instr_reg[15:8]),
        .carry     (carry),
        .zero      (zero),
        .overflow  (overflow),
        .negative  (negative),
        .is_branch (dec_branch),
        .take      (dec_take)
    );

    // phase sequencer: one instruction cycle is four clocks
    always_comb begin
        case (state_reg)
            branch_pkg::ST_IDLE: begin
                if (wr_ack && reg_idx == branch_pkg::REG_INSTR) begin
                    state_next = branch_pkg::ST_Q1;
                end else begin
                    state_next = branch_pkg::ST_IDLE;
                end
            end
            branch_pkg::ST_Q1: state_next = branch_pkg::ST_Q2;
            branch_pkg::ST_Q2: state_next = branch_pkg::ST_Q3;
            branch_pkg::ST_Q3: state_next = branch_pkg::ST_Q4;
            branch_pkg::ST_Q4: begin
                if (taken_reg) begin
                    state_next = branch_pkg::ST_N1; // RL9
                end else begin
                    state_next = branch_pkg::ST_IDLE; // RL9
                end
            end
            branch_pkg::ST_N1: state_next = branch_pkg::ST_N2; // RL11
            branch_pkg::ST_N2: state_next = branch_pkg::ST_N3;
            branch_pkg::ST_N3: state_next = branch_pkg::ST_N4;
            branch_pkg::ST_N4: state_next = branch_pkg::ST_IDLE;
            default:           state_next = branch_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= branch_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            busy_reg <= 1'h0;
        end else begin
            busy_reg <= state_next != branch_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            instr_reg <= branch_pkg::INSTR_RESET;
        end else if (wr_ack && reg_idx == branch_pkg::REG_INSTR) begin
            instr_reg <= instr_merged[branch_pkg::INSTR_WIDTH-1:0];
        end
    end

    // read literal phase: low byte, signed, doubled to a byte displacement
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            disp_reg <= '0;
        end else if (state_reg == branch_pkg::ST_Q2) begin
            disp_reg <= PC_WIDTH'($signed({instr_reg[7:0], 1'h0})); // RL6 RL7
        end
    end

    // process phase: condition sampled from the flags, which the unit reads but never writes
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            taken_reg   <= 1'h0;
            foreign_reg <= 1'h0;
        end else if (state_reg == branch_pkg::ST_Q3) begin
            taken_reg   <= dec_branch && dec_take; // RL1 RL2 RL3 RL4 RL5 RL11
            foreign_reg <= !dec_branch;
        end
    end

    // decode phase keeps the instruction address as the branch base, then advances the fetch address one word
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pc_reg   <= '0;
            base_reg <= '0;
        end else if (state_reg == branch_pkg::ST_IDLE && wr_ack && reg_idx == branch_pkg::REG_PC) begin
            // program words are even, so bit zero of a written pc is dropped
            pc_reg <= {pc_merged[PC_WIDTH-1:1], 1'h0};
        end else if (state_reg == branch_pkg::ST_Q1) begin
            base_reg <= pc_reg;
            pc_reg   <= pc_reg + step; // RL9 RL10
        end else if (state_reg == branch_pkg::ST_Q4 && taken_reg) begin
            pc_reg <= pc_reg + disp_reg; // RL8
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pc_write_reg <= 1'h0;
        end else begin
            pc_write_reg <= state_reg == branch_pkg::ST_Q4 && taken_reg; // RL12
        end
    end

    // counters wrap silently; software reads differences
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            taken_cnt_reg <= '0;
            fall_cnt_reg  <= '0;
        end else if (state_reg == branch_pkg::ST_Q4) begin
            if (taken_reg) begin
                taken_cnt_reg <= taken_cnt_reg + CNT_WIDTH'(1);
            end else if (!foreign_reg) begin
                fall_cnt_reg <= fall_cnt_reg + CNT_WIDTH'(1);
            end
        end
    end

    assign avs_readdata    = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign pc_value        = pc_reg;
    assign pc_write        = pc_write_reg;
    assign busy            = busy_reg;
    assign taken           = taken_reg;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    sequence s_first_cycle;
        state_reg == branch_pkg::ST_Q1 ##1 state_reg == branch_pkg::ST_Q2 ##1
        state_reg == branch_pkg::ST_Q3 ##1 state_reg == branch_pkg::ST_Q4;
    endsequence

    sequence s_idle_cycle;
        // the registered pc strobe of the first cycle still shows during n1
        state_reg == branch_pkg::ST_N1 ##1
        state_reg == branch_pkg::ST_N2 && !pc_write_reg ##1
        state_reg == branch_pkg::ST_N3 && !pc_write_reg ##1
        state_reg == branch_pkg::ST_N4 && !pc_write_reg;
    endsequence

    property p_decide(logic [3:0] op, logic want);
        (state_reg == branch_pkg::ST_Q3 && instr_reg[15:8] == {branch_pkg::OP_GROUP, op})
            |=> taken_reg == $past(want);
    endproperty

    neg_decide_a : assert property (p_decide(branch_pkg::OP_NEG, negative)) // RL1
        else $error("negative branch decision wrong");
    carry_decide_a : assert property (p_decide(branch_pkg::OP_CARRY_CLR, !carry)) // RL2
        else $error("carry clear branch decision wrong");
    notneg_decide_a : assert property (p_decide(branch_pkg::OP_NOT_NEG, !negative)) // RL3
        else $error("not negative branch decision wrong");
    ovf_decide_a : assert property (p_decide(branch_pkg::OP_NO_OVF, !overflow)) // RL4
        else $error("no overflow branch decision wrong");
    nonzero_decide_a : assert property (p_decide(branch_pkg::OP_NONZERO, !zero)) // RL5
        else $error("nonzero branch decision wrong");

    offset_extend_a : assert property ( // RL6
        state_reg == branch_pkg::ST_Q3 |-> disp_reg == PC_WIDTH'($signed({instr_reg[7:0], 1'h0})))
        else $error("displacement not doubled signed low byte");

    target_addr_a : assert property ( // RL8
        pc_write_reg |-> pc_reg == base_reg + step + disp_reg)
        else $error("taken target not base plus two plus displacement");

    taken_cycles_a : assert property ( // RL9
        s_first_cycle ##0 taken_reg |=> s_idle_cycle ##1 state_reg == branch_pkg::ST_IDLE)
        else $error("taken branch not two cycles");

    taken_write_a : assert property ( // RL8
        state_reg == branch_pkg::ST_Q4 && taken_reg |=> pc_write_reg ##1 $stable(pc_reg)[*3])
        else $error("taken branch pc write misplaced");

    fall_through_a : assert property ( // RL10
        s_first_cycle ##0 !taken_reg |=> state_reg == branch_pkg::ST_IDLE && pc_reg == base_reg + step)
        else $error("fall through pc wrong");

    fall_quiet_a : assert property ( // RL12
        state_reg == branch_pkg::ST_Q4 && !taken_reg |=> !pc_write_reg && $stable(pc_reg))
        else $error("not taken branch wrote pc");

    second_quiet_a : assert property ( // RL11
        state_reg inside {branch_pkg::ST_N1, branch_pkg::ST_N2, branch_pkg::ST_N3}
            |=> $stable(pc_reg) && $stable(taken_reg) && !pc_write_reg)
        else $error("second cycle did work");

    busy_hold_a : assert property (
        avs_write && reg_idx == branch_pkg::REG_INSTR && state_reg != branch_pkg::ST_IDLE
            |-> avs_waitrequest)
        else $error("instruction write accepted while busy");

    // a master that misses the low cycle would stall, so the pulse must rearm at once
    wait_pulse_a : assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");

    pc_pulse_a : assert property ( // RL11
        pc_write_reg |=> !pc_write_reg)
        else $error("pc write strobe longer than one cycle");

    fetch_step_a : assert property ( // RL9
        state_reg == branch_pkg::ST_Q1 |=> pc_reg == base_reg + step)
        else $error("fetch address not one word on");

    taken_count_a : assert property ( // RL9
        state_reg == branch_pkg::ST_Q4 && taken_reg |=> taken_cnt_reg == $past(taken_cnt_reg) + CNT_WIDTH'(1))
        else $error("taken branch not counted");

    fall_count_a : assert property ( // RL10
        state_reg == branch_pkg::ST_Q4 && !taken_reg && !foreign_reg
            |=> fall_cnt_reg == $past(fall_cnt_reg) + CNT_WIDTH'(1))
        else $error("branch not taken not counted");

endmodule : conditional_branch_unit

//--- branch_pkg.sv
package branch_pkg;

    localparam int INSTR_WIDTH  = 16;
    localparam int BUS_AW       = 5;
    localparam int BUS_DW       = 32;
    localparam int PC_MIN_WIDTH = 10;
    localparam int PC_MAX_WIDTH = 32;
    localparam int PC_STEP      = 2;

    localparam logic [3:0] OP_GROUP     = 4'hE;
    localparam logic [3:0] OP_NEG       = 4'h6;
    localparam logic [3:0] OP_CARRY_CLR = 4'h3;
    localparam logic [3:0] OP_NOT_NEG   = 4'h7;
    localparam logic [3:0] OP_NO_OVF    = 4'h5;
    localparam logic [3:0] OP_NONZERO   = 4'h1;

    localparam logic [2:0] REG_INSTR     = 3'h0;
    localparam logic [2:0] REG_PC        = 3'h1;
    localparam logic [2:0] REG_STATUS    = 3'h2;
    localparam logic [2:0] REG_TAKEN_CNT = 3'h3;
    localparam logic [2:0] REG_FALL_CNT  = 3'h4;

    localparam int ST_BUSY_BIT    = 0;
    localparam int ST_TAKEN_BIT   = 1;
    localparam int ST_FOREIGN_BIT = 2;
    localparam int ST_SECOND_BIT  = 3;
    localparam int ST_CARRY_BIT   = 4;
    localparam int ST_ZERO_BIT    = 5;
    localparam int ST_OVF_BIT     = 6;
    localparam int ST_NEG_BIT     = 7;

    localparam logic [INSTR_WIDTH-1:0] INSTR_RESET = 16'h0000;

    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_Q1   = 9'h002,
        ST_Q2   = 9'h004,
        ST_Q3   = 9'h008,
        ST_Q4   = 9'h010,
        ST_N1   = 9'h020,
        ST_N2   = 9'h040,
        ST_N3   = 9'h080,
        ST_N4   = 9'h100
    } seq_state_e;

endpackage : branch_pkg

module cond_branch_decode (
    input  wire logic [7:0] opcode_hi,
    input  wire logic       carry,
    input  wire logic       zero,
    input  wire logic       overflow,
    input  wire logic       negative,
    output logic            is_branch,
    output logic            take
);

    always_comb begin
        is_branch = 1'h0;
        take      = 1'h0;
        if (opcode_hi[7:4] == branch_pkg::OP_GROUP) begin
            case (opcode_hi[3:0])
                branch_pkg::OP_NEG: begin
                    is_branch = 1'h1;
                    take      = negative; // RL1
                end
                branch_pkg::OP_CARRY_CLR: begin
                    is_branch = 1'h1;
                    take      = !carry; // RL2
                end
                branch_pkg::OP_NOT_NEG: begin
                    is_branch = 1'h1;
                    take      = !negative; // RL3
                end
                branch_pkg::OP_NO_OVF: begin
                    is_branch = 1'h1;
                    take      = !overflow; // RL4
                end
                branch_pkg::OP_NONZERO: begin
                    is_branch = 1'h1;
                    take      = !zero; // RL5
                end
                default: begin
                    is_branch = 1'h0;
                    take      = 1'h0;
                end
            endcase
        end
    end

endmodule : cond_branch_decode

//--- core_flags_model.sv
module core_flags_model #(
    parameter int PC_WIDTH = 16
) (
    input  wire logic                mclk,
    input  wire logic                rstn,
    input  wire logic [3:0]          flags_req,
    input  wire logic                busy,
    input  wire logic                pc_write,
    input  wire logic [PC_WIDTH-1:0] pc_value,
    output logic                     carry,
    output logic                     zero,
    output logic                     overflow,
    output logic                     negative,
    output logic      [PC_WIDTH-1:0] core_pc
);
    timeunit 1ns;
    timeprecision 1ps;

    // flags only move between instructions, as the alu holds them while a branch decides
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            {negative, overflow, zero, carry} <= 4'h0;
        end else if (!busy) begin
            {negative, overflow, zero, carry} <= flags_req;
        end
    end

    // core copy of the program counter, only moved by a write strobe
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            core_pc <= '0;
        end else if (pc_write) begin
            core_pc <= pc_value;
        end
    end
endmodule : core_flags_model

//--- test_conditional_branch_unit.sv
module test_conditional_branch_unit;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk, rstn, avs_read, avs_write, avs_waitrequest;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable, flags_req;
    logic        carry, zero, overflow, negative, pc_write, busy, taken;
    logic [15:0] pc_value, core_pc;
    logic [31:0] rd_q[$];
    logic [15:0] pc_q[$];
    logic [7:0]  ops[7] = '{8'hE6, 8'hE3, 8'hE7, 8'hE5, 8'hE1, 8'hE2, 8'hD0};
    int          n_errors = 0;
    int          tests_run = 0;
    int          n_taken = 0;
    int          n_fall = 0;

    conditional_branch_unit #(.PC_WIDTH(16), .CNT_WIDTH(16)) dut_u (
        .mclk(mclk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .carry(carry),
        .zero(zero), .overflow(overflow), .negative(negative), .pc_value(pc_value),
        .pc_write(pc_write), .busy(busy), .taken(taken));

    core_flags_model #(.PC_WIDTH(16)) partner_u (
        .mclk(mclk), .rstn(rstn), .flags_req(flags_req), .busy(busy), .pc_write(pc_write),
        .pc_value(pc_value), .carry(carry), .zero(zero), .overflow(overflow),
        .negative(negative), .core_pc(core_pc));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_pc(input logic [15:0] got, input logic [15:0] exp);
        check_word({16'h0000, got}, {16'h0000, exp});
    endtask : check_pc

    task automatic check_count(input int got, input int exp);
        check_word(got, exp);
    endtask : check_count

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up

    // one edge first, so a release and the next raise never share a time step
    task automatic bus_access(input logic wr, input logic [2:0] reg_sel, input logic [31:0] data);
        @(posedge mclk);
        avs_address   <= {reg_sel, 2'b00};
        avs_writedata <= data;
        avs_write     <= wr;
        avs_read      <= !wr;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus_access

    task automatic bus_read(input logic [2:0] reg_sel, input logic [31:0] exp);
        rd_q.push_back(exp);
        bus_access(1'b0, reg_sel, 32'h00000000);
    endtask : bus_read

    task automatic run_branch(input logic [7:0] op, input logic [7:0] off, input logic [3:0] fl,
                              input logic [15:0] pc0);
        logic        tk;
        logic        foreign;
        logic [15:0] next_pc;
        int          cycles;
        foreign = 1'b0;
        case (op)
            {branch_pkg::OP_GROUP, branch_pkg::OP_NEG}: tk = fl[3];
            {branch_pkg::OP_GROUP, branch_pkg::OP_CARRY_CLR}: tk = !fl[0];
            {branch_pkg::OP_GROUP, branch_pkg::OP_NOT_NEG}: tk = !fl[3];
            {branch_pkg::OP_GROUP, branch_pkg::OP_NO_OVF}: tk = !fl[2];
            {branch_pkg::OP_GROUP, branch_pkg::OP_NONZERO}: tk = !fl[1];
            default: begin
                tk = 1'b0;
                foreign = 1'b1;
            end
        endcase
        next_pc = pc0 + 16'h0002 + {{7{off[7]}}, off, 1'b0};
        if (!tk) next_pc = pc0 + 16'h0002;
        flags_req <= fl;
        bus_access(1'b1, branch_pkg::REG_PC, {16'h0000, pc0});
        if (tk) pc_q.push_back(next_pc);
        bus_access(1'b1, branch_pkg::REG_INSTR, {16'h0000, op, off});
        cycles = 0;
        do begin
            @(posedge mclk);
            if (busy === 1'b1) cycles++;
        end while (busy === 1'b1);
        check_count(cycles, tk ? 8 : 4);
        check_word({31'h00000000, taken}, {31'h00000000, tk});
        bus_read(branch_pkg::REG_PC, {16'h0000, next_pc});
        bus_read(branch_pkg::REG_STATUS, {24'h000000, fl, 1'b0, foreign, tk, 1'b0});
        if (tk) check_pc(core_pc, next_pc);
        if (tk) n_taken++;
        else if (!foreign) n_fall++;
    endtask : run_branch

    // a result is whatever the design shows: accepted read data, or a pc write strobe
    always @(posedge mclk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (rd_q.size() == 0) check_count(1, 0);
            else check_word(avs_readdata, rd_q.pop_front());
        end
        if (pc_write === 1'b1) begin
            if (pc_q.size() == 0) check_pc(pc_value, ~pc_value);
            else check_pc(pc_value, pc_q.pop_front());
        end
    end

    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        wrap_up();
    end

    initial begin
        rstn = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'hF;
        flags_req = 4'h0;
        void'($urandom(32'h619148d0));
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        bus_read(branch_pkg::REG_PC, 32'h00000000);
        bus_read(branch_pkg::REG_TAKEN_CNT, 32'h00000000);
        bus_read(branch_pkg::REG_FALL_CNT, 32'h00000000);
        $display("reset values test done");
        // both flag polarities and both offset extremes for each of the five branch opcodes
        for (int i = 0; i < 5; i++) begin
            run_branch(ops[i], 8'h7F, 4'h0, 16'h1000);
            run_branch(ops[i], 8'h80, 4'hF, 16'h1000);
        end
        $display("opcode sweep test done");
        for (int i = 0; i < 24; i++) begin
            run_branch(ops[$urandom_range(6, 0)], 8'($urandom), 4'($urandom), {15'($urandom), 1'b0});
        end
        $display("random branch test done");
        // a pc write right behind a taken branch must stall, not be lost
        flags_req <= 4'h0;
        bus_access(1'b1, branch_pkg::REG_PC, 32'h00000200);
        pc_q.push_back(16'h0206);
        bus_access(1'b1, branch_pkg::REG_INSTR, 32'h0000E302);
        bus_access(1'b1, branch_pkg::REG_PC, 32'h00000400);
        n_taken++;
        bus_read(branch_pkg::REG_PC, 32'h00000400);
        $display("stalled write test done");
        bus_access(1'b1, branch_pkg::REG_STATUS, 32'hFFFFFFFF);
        bus_access(1'b1, 3'h7, 32'hFFFFFFFF);
        bus_read(branch_pkg::REG_STATUS, 32'h00000002);
        bus_read(3'h5, 32'h00000000);
        bus_read(branch_pkg::REG_PC, 32'h00000400);
        bus_read(branch_pkg::REG_TAKEN_CNT, n_taken);
        bus_read(branch_pkg::REG_FALL_CNT, n_fall);
        repeat (2) @(posedge mclk);
        check_count(pc_q.size(), 0);
        check_count(rd_q.size(), 0);
        $display("read-only and counter test done");
        wrap_up();
    end
endmodule : test_conditional_branch_unit
